// >>> logic/cia_pkg.sv
// Contract
// - Finish current instruction before interrupt entry.
// - Stack PC, then fetch from source vector.
// - Entry sequence lasts exactly five instruction cycles.
// - Trap return pops address in reverse order.
// - Trap return sets enable, resumes at address.
// - Fixed priority: edge, timer one, timer two, trap.
// - Enable gates peripheral requests, never the trap.
// - Software trap always enters, enable ignored.
// - Trap entry stacks PC and clears enable.
// - Plain return restores PC only, enable untouched.
// - Indexed: 8-bit offset plus low 11 pointer bits.
// - Indirect: pointer addresses data memory directly.
// - Direct: 8-bit field is data address.
// - Immediate: 8-bit field is the operand.
// - Inherent: opcode only, no operand bytes.
// - Absolute 11-bit address, long jump and call only.
// - Short jump displacement spans -31 to +32.
// - Reset clears enable; software or a trap return sets it.
// - Push subtracts two, pull adds two, next free.
// - Return address pushed low byte first.
// - Pointer top bit selects data or program space.
`default_nettype none
package cia_pkg;
    // One instruction cycle is 1 us on a 20 MHz clock
    localparam int          CYC_NS      = 1000;
    localparam int          CLK_MHZ     = 20;
    localparam int          CYC_CLKS    = CYC_NS * CLK_MHZ / 1000;
    localparam logic [4:0]  TICK_LAST   = 5'(CYC_CLKS - 1);
    localparam int          SEQ_CYCLES  = 5;
    localparam logic [2:0]  SEQ_LAST    = 3'(SEQ_CYCLES - 1);
    localparam logic [3:0]  SP_RESET    = 4'hf;
    localparam logic [10:0] PC_RESET    = 11'h000;
    localparam logic [10:0] DISP_BIAS   = 11'h01f;
    // Vector targets per source
    localparam logic [10:0] VEC_EDGE    = 11'h7f8;
    localparam logic [10:0] VEC_PRIM    = 11'h7fa;
    localparam logic [10:0] VEC_SEC     = 11'h7fc;
    localparam logic [10:0] VEC_TRAP    = 11'h7fe;
    // Source codes, higher value is higher priority
    localparam logic [1:0]  SRC_TRAP    = 2'h0;
    localparam logic [1:0]  SRC_SEC     = 2'h1;
    localparam logic [1:0]  SRC_PRIM    = 2'h2;
    localparam logic [1:0]  SRC_EDGE    = 2'h3;

    typedef enum logic [2:0] {
        MD_INDEXED  = 3'h0,
        MD_INDIRECT = 3'h1,
        MD_DIRECT   = 3'h2,
        MD_IMMED    = 3'h3,
        MD_INHERENT = 3'h4,
        MD_ABSOLUTE = 3'h5,
        MD_RELATIVE = 3'h6
    } cia_mode_e;

    typedef enum logic [2:0] {
        CL_PLAIN      = 3'h0,
        CL_SHORT_JUMP = 3'h1,
        CL_LONG_JUMP  = 3'h2,
        CL_SUB_CALL   = 3'h3,
        CL_SUB_RETURN = 3'h4,
        CL_TRAP_RET   = 3'h5,
        CL_TRAP       = 3'h6
    } cia_class_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PUSH = 3'b010,
        ST_POP  = 3'b100
    } cia_state_e;
endpackage : cia_pkg
`default_nettype wire

// >>> logic/cia_core.sv
`default_nettype none
module cia_core
    import cia_pkg::*;
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_B,
    input  wire logic        I_EDGE_WAKEUP_REQUEST,
    input  wire logic        I_PRIMARY_TIMER_REQUEST,
    input  wire logic        I_SECONDARY_TIMER_REQUEST,
    input  wire logic        I_EXEC,
    input  wire logic [2:0]  I_CLASS,
    input  wire logic [2:0]  I_MODE,
    input  wire logic [1:0]  I_LEN,
    input  wire logic [7:0]  I_OPND1,
    input  wire logic [7:0]  I_OPND2,
    input  wire logic [11:0] I_XPTR,
    input  wire logic        I_G_SET,
    input  wire logic        I_G_CLR,
    input  wire logic        I_SP_LOAD,
    input  wire logic [3:0]  I_SP_VALUE,
    output logic             O_READY,
    output logic [10:0]      O_PC,
    output logic [11:0]      O_EA,
    output logic [7:0]       O_OPERAND,
    output logic             O_OPERAND_VALID,
    output logic [3:0]       O_SP,
    output logic             O_G,
    output logic             O_ENTRY,
    output logic [1:0]       O_SOURCE
);
    // Sequencer state, working registers and their next values
    cia_state_e  state;
    cia_state_e  next_state;
    logic [4:0]  div;
    logic [2:0]  seq;
    logic [2:0]  next_seq;
    logic [10:0] pc;
    logic [10:0] next_pc;
    logic [10:0] ret;
    logic [10:0] next_ret;
    logic [10:0] tgt;
    logic [10:0] next_tgt;
    logic [3:0]  sp;
    logic [3:0]  next_sp;
    logic        g;
    logic        next_g;
    logic        entry;
    logic        next_entry;
    logic        return_from_trap;
    logic        next_return_from_trap;
    logic        next_pulse;
    logic [1:0]  src;
    logic [1:0]  next_src;
    // Sixteen-byte return stack; only the pointer reaches the outside
    logic [7:0]  stk [16];

    // Priority encoder; trap sits lowest
    // Shared by the vector choice and the reported source, so one function
    function automatic logic [1:0] pick_src(input logic e, input logic p,
                                            input logic s);
        pick_src = e ? SRC_EDGE : p ? SRC_PRIM : s ? SRC_SEC : SRC_TRAP;
    endfunction

    // Vector target per source code
    function automatic logic [10:0] vec_of(input logic [1:0] code);
        case (code)
            SRC_EDGE: vec_of = VEC_EDGE;
            SRC_PRIM: vec_of = VEC_PRIM;
            SRC_SEC:  vec_of = VEC_SEC;
            default:  vec_of = VEC_TRAP;
        endcase
    endfunction

    // Instruction-cycle enable and boundary decode
    wire tick    = (div == TICK_LAST);
    wire st_idle = (state == ST_IDLE);
    wire st_push = (state == ST_PUSH);
    wire st_pop  = (state == ST_POP);
    // Requests are levels; a masked one is simply not seen yet
    wire per_req = I_EDGE_WAKEUP_REQUEST | I_PRIMARY_TIMER_REQUEST
                 | I_SECONDARY_TIMER_REQUEST;
    wire per_hit = g & per_req;
    wire take_irq = st_idle & tick & per_hit;
    wire take    = st_idle & tick & ~per_hit & I_EXEC;
    wire [1:0] irq_src = pick_src(I_EDGE_WAKEUP_REQUEST,
                                  I_PRIMARY_TIMER_REQUEST,
                                  I_SECONDARY_TIMER_REQUEST);
    // Last tick of the five-cycle stack sequence
    wire seq_end = tick & (seq == SEQ_LAST);

    // Effective address forming
    wire [10:0] idx_sum = I_XPTR[10:0] + {3'h0, I_OPND1};
    // Space select rides above the sum, so a carry never changes space
    wire [11:0] idx_ea  = {I_XPTR[11], idx_sum};
    wire [11:0] ind_ea  = {4'h0, I_XPTR[7:0]};
    wire [11:0] dir_ea  = {4'h0, I_OPND1};
    wire [10:0] abs_tgt = {I_OPND1[2:0], I_OPND2};
    // Biased 6-bit field: 0 gives -31, 63 gives +32
    wire [10:0] rel_tgt = pc + {5'h0, I_OPND1[5:0]} - DISP_BIAS;
    // Fall-through address, also the return address of a call
    wire [10:0] seq_pc  = pc + {9'h0, I_LEN};
    // Only indexed and absolute modes may redirect a long jump or a call
    wire        mode_idx = (I_MODE == MD_INDEXED);
    wire        long_ok  = mode_idx | (I_MODE == MD_ABSOLUTE);
    wire [10:0] jmp_tgt  = mode_idx ? idx_sum : abs_tgt;
    // Modes without a memory address report zero
    wire [11:0] ea_dec =
        (I_MODE == MD_INDEXED)  ? idx_ea :
        (I_MODE == MD_INDIRECT) ? ind_ea :
        (I_MODE == MD_DIRECT)   ? dir_ea :
        (I_MODE == MD_ABSOLUTE) ? {1'b1, abs_tgt} : 12'h000;
    wire        imm_mode = (I_MODE == MD_IMMED);

    // Stack port: low byte first on push, high byte first on pull
    wire [3:0]  sp_dn1  = sp - 4'h1;
    wire [3:0]  sp_up1  = sp + 4'h1;
    wire [3:0]  sp_up2  = sp + 4'h2;
    // Writes happen on the first two ticks of a push only
    wire        stk_we  = st_push & tick & (seq < 3'h2);
    wire [3:0]  stk_wa  = (seq == 3'h0) ? sp : sp_dn1;
    wire [7:0]  stk_wd  = (seq == 3'h0) ? ret[7:0] : {5'h0, ret[10:8]};
    // Pull reads are combinational, so no tick is lost waiting for data
    wire [7:0]  pop_hi  = stk[sp_up1];
    wire [7:0]  pop_lo  = stk[sp_up2];

    // Ready is a handshake and may be combinational; the rest mirror registers
    assign O_READY = st_idle & tick & ~per_hit;
    assign O_PC    = pc;
    assign O_SP    = sp;
    assign O_G     = g;
    assign O_SOURCE = src;

    // Next-state logic for the control sequencer
    always_comb begin
        next_state = state;
        next_seq   = seq;
        next_pc    = pc;
        next_ret   = ret;
        next_tgt   = tgt;
        next_sp    = I_SP_LOAD ? I_SP_VALUE : sp;
        next_g     = g;
        next_entry = entry;
        next_return_from_trap  = return_from_trap;
        next_src   = src;
        next_pulse = 1'b0;
        // Software writes of the enable; a clear beats a set in one cycle
        if (I_G_SET) begin
            next_g = 1'b1;
        end
        if (I_G_CLR) begin
            next_g = 1'b0;
        end
        case (state)
            // Idle: one decision per boundary, enabled requests before instructions
            ST_IDLE: begin
                next_seq = 3'h0;
                if (take_irq) begin
                    next_state = ST_PUSH;
                    next_ret   = pc;
                    next_tgt   = vec_of(irq_src);
                    next_src   = irq_src;
                    next_entry = 1'b1;
                end else if (take) begin
                    case (I_CLASS)
                        CL_SHORT_JUMP: next_pc = rel_tgt;
                        CL_LONG_JUMP: begin
                            next_pc = long_ok ? jmp_tgt : seq_pc;
                        end
                        // A call shares the push but never touches the enable
                        CL_SUB_CALL: begin
                            if (long_ok) begin
                                next_state = ST_PUSH;
                                next_ret   = seq_pc;
                                next_tgt   = jmp_tgt;
                                next_entry = 1'b0;
                            end else begin
                                next_pc = seq_pc;
                            end
                        end
                        CL_SUB_RETURN: begin
                            next_state = ST_POP;
                            next_return_from_trap  = 1'b0;
                        end
                        CL_TRAP_RET: begin
                            next_state = ST_POP;
                            next_return_from_trap  = 1'b1;
                        end
                        // Trap stacks the next address so the handler resumes after it
                        CL_TRAP: begin
                            next_state = ST_PUSH;
                            next_ret   = seq_pc;
                            next_tgt   = VEC_TRAP;
                            next_src   = SRC_TRAP;
                            next_entry = 1'b1;
                        end
                        default: next_pc = seq_pc;
                    endcase
                end
            end
            // Push: low byte on the first tick, high byte and pointer on the second
            ST_PUSH: begin
                if (tick) begin
                    next_seq = seq + 3'h1;
                end
                if (tick & (seq == 3'h1)) begin
                    next_sp = sp - 4'h2;
                end
                // The last tick loads the target; only an entry clears the enable
                if (seq_end) begin
                    next_state = ST_IDLE;
                    next_pc    = tgt;
                    next_pulse = entry;
                    if (entry) begin
                        next_g = 1'b0;
                    end
                end
            end
            // Pull: high byte first, then low byte and pointer, reverse of the push
            ST_POP: begin
                if (tick) begin
                    next_seq = seq + 3'h1;
                end
                if (tick & (seq == 3'h0)) begin
                    next_ret[10:8] = pop_hi[2:0];
                end
                if (tick & (seq == 3'h1)) begin
                    next_ret[7:0] = pop_lo;
                    next_sp       = sp + 4'h2;
                end
                // A trap return sets the enable over any software write that cycle
                if (seq_end) begin
                    next_state = ST_IDLE;
                    next_pc    = ret;
                    if (return_from_trap) begin
                        next_g = 1'b1;
                    end
                end
            end
            // Unreachable with one-hot codes; recover to idle
            default: next_state = ST_IDLE;
        endcase
    end

    // Instruction-cycle divider
    // Ticks once every twenty clocks; every sequencing step waits for it
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            div <= 5'h00;
        end else begin
            div <= tick ? 5'h00 : div + 5'h01;
        end
    end

    // Sequencer and core registers
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state   <= ST_IDLE;
            seq     <= 3'h0;
            pc      <= PC_RESET;
            ret     <= 11'h000;
            tgt     <= 11'h000;
            sp      <= SP_RESET;
            g       <= 1'b0;
            entry   <= 1'b0;
            return_from_trap    <= 1'b0;
            src     <= SRC_TRAP;
            O_ENTRY <= 1'b0;
        end else begin
            state   <= next_state;
            seq     <= next_seq;
            pc      <= next_pc;
            ret     <= next_ret;
            tgt     <= next_tgt;
            sp      <= next_sp;
            g       <= next_g;
            entry   <= next_entry;
            return_from_trap    <= next_return_from_trap;
            src     <= next_src;
            O_ENTRY <= next_pulse;
        end
    end

    // Operand outputs, captured when an instruction is taken
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_EA            <= 12'h000;
            O_OPERAND       <= 8'h00;
            O_OPERAND_VALID <= 1'b0;
        end else if (take) begin
            O_EA            <= ea_dec;
            O_OPERAND       <= imm_mode ? I_OPND1 : 8'h00;
            O_OPERAND_VALID <= imm_mode;
        end
    end

    // Stack storage has no reset; contents are only meaningful after a push
    always_ff @(posedge I_CLOCK) begin
        if (stk_we) begin
            stk[stk_wa] <= stk_wd;
        end
    end
endmodule : cia_core
`default_nettype wire

// >>> verif/cia_chk.sv
`default_nettype none
module cia_chk
    import cia_pkg::*;
(
    input wire logic        I_CLOCK,
    input wire logic        I_RST_B,
    input wire logic        I_EDGE_WAKEUP_REQUEST,
    input wire logic        I_PRIMARY_TIMER_REQUEST,
    input wire logic        I_SECONDARY_TIMER_REQUEST,
    input wire logic        I_EXEC,
    input wire logic [2:0]  I_CLASS,
    input wire logic [2:0]  I_MODE,
    input wire logic [7:0]  I_OPND1,
    input wire logic [7:0]  I_OPND2,
    input wire logic [11:0] I_XPTR,
    input wire logic        I_SP_LOAD,
    input wire logic        O_READY,
    input wire logic [10:0] O_PC,
    input wire logic [11:0] O_EA,
    input wire logic [7:0]  O_OPERAND,
    input wire logic        O_OPERAND_VALID,
    input wire logic [3:0]  O_SP,
    input wire logic        O_G,
    input wire logic        O_ENTRY,
    input wire logic [1:0]  O_SOURCE
);
    // Taken instruction, any pending request, vector of the entered source
    wire logic acc = O_READY && I_EXEC;
    wire logic reqs = I_EDGE_WAKEUP_REQUEST || I_PRIMARY_TIMER_REQUEST
                   || I_SECONDARY_TIMER_REQUEST;
    wire logic [10:0] vec = (O_SOURCE == SRC_EDGE) ? VEC_EDGE : (O_SOURCE == SRC_PRIM) ? VEC_PRIM
                          : (O_SOURCE == SRC_SEC) ? VEC_SEC : VEC_TRAP;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);
    // Reset is checked while it is asserted, so it cannot be its own disable
    property p_rst_g; disable iff (1'b0) !I_RST_B |-> !O_G; endproperty
    a_rst_g: assert property (p_rst_g) else $error("enable set in reset");
    property p_gate; (O_G && reqs) |-> !O_READY; endproperty
    a_gate: assert property (p_gate) else $error("ready with enabled request");
    property p_vec; O_ENTRY |-> (O_PC == vec) && !O_G; endproperty
    a_vec: assert property (p_vec) else $error("entry vector or enable wrong");
    property p_len; (acc && I_CLASS == CL_TRAP) |-> ##101 O_ENTRY; endproperty
    a_len: assert property (p_len) else $error("trap entry length wrong");
    property p_sp; ($changed(O_SP) && !$past(I_SP_LOAD)) |-> (O_SP == $past(O_SP) - 4'h2)
        || (O_SP == $past(O_SP) + 4'h2); endproperty
    a_sp: assert property (p_sp) else $error("stack step not two");
    // Priority is judged on the levels seen when the entry was accepted
    property p_pri; (O_ENTRY && O_SOURCE != SRC_TRAP) |-> O_SOURCE == $past(
        I_EDGE_WAKEUP_REQUEST ? SRC_EDGE : I_PRIMARY_TIMER_REQUEST ? SRC_PRIM : SRC_SEC, 101);
        endproperty
    a_pri: assert property (p_pri) else $error("priority order wrong");
    property p_ret; (acc && I_CLASS == CL_TRAP_RET) |-> ##102 O_G; endproperty
    a_ret: assert property (p_ret) else $error("trap return left enable clear");
    property p_sub; (acc && I_CLASS == CL_SUB_RETURN) |-> ##102 O_G == $past(O_G, 102); endproperty
    a_sub: assert property (p_sub) else $error("plain return moved enable");
    property p_rel; (acc && I_CLASS == CL_SHORT_JUMP) |=> O_PC == 11'($past(O_PC)
        + 11'($past(I_OPND1[5:0])) - DISP_BIAS); endproperty
    a_rel: assert property (p_rel) else $error("short jump target wrong");
    property p_abs; (acc && I_CLASS == CL_LONG_JUMP && I_MODE == MD_ABSOLUTE)
        |=> O_PC == {$past(I_OPND1[2:0]), $past(I_OPND2)}; endproperty
    a_abs: assert property (p_abs) else $error("absolute target wrong");
    property p_idx; (acc && I_CLASS == CL_PLAIN && I_MODE == MD_INDEXED) |=> O_EA ==
        {$past(I_XPTR[11]), 11'($past(I_XPTR[10:0]) + 11'($past(I_OPND1)))}; endproperty
    a_idx: assert property (p_idx) else $error("indexed address wrong");
    property p_imm; (acc && I_MODE == MD_IMMED) |=> O_OPERAND_VALID
        && O_OPERAND == $past(I_OPND1); endproperty
    a_imm: assert property (p_imm) else $error("immediate operand wrong");
endmodule // cia_chk
bind cia_core cia_chk u_chk (.I_CLOCK, .I_RST_B, .I_EDGE_WAKEUP_REQUEST, .I_PRIMARY_TIMER_REQUEST,
    .I_SECONDARY_TIMER_REQUEST, .I_EXEC, .I_CLASS, .I_MODE, .I_OPND1, .I_OPND2, .I_XPTR,
    .I_SP_LOAD, .O_READY, .O_PC, .O_EA, .O_OPERAND, .O_OPERAND_VALID, .O_SP, .O_G, .O_ENTRY,
    .O_SOURCE);
`default_nettype wire

// >>> verif/cia_periph.sv
`default_nettype none
module cia_periph (
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic [2:0] i_raise,
    input  wire logic       i_entry,
    input  wire logic [1:0] i_source,
    output logic [2:0]      o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bit 2 edge, 1 primary, 0 secondary; a level stays up until its own entry
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_req <= 3'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (i_raise[k]) o_req[k] <= 1'b1;
                else if (i_entry && i_source == 2'(k + 1)) o_req[k] <= 1'b0;
            end
        end
    end
endmodule // cia_periph
`default_nettype wire

// >>> verif/cia_core_tb_top.sv
`default_nettype none
module cia_core_tb_top import cia_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_b = 1'b1, exec = 1'b0, g_set = 1'b0, g_clr = 1'b0;
    logic [2:0]  cls = 3'h0, mode = 3'h0, raise = 3'h0;
    logic [1:0]  len = 2'h0;
    logic [7:0]  op1 = 8'h00, op2 = 8'h00;
    logic [11:0] xptr = 12'h000;
    logic [10:0] epc = 11'h000;
    logic [10:0] vt [4] = '{VEC_TRAP, VEC_SEC, VEC_PRIM, VEC_EDGE};
    wire  [2:0]  req;
    wire         ready, ent, g, opv;
    wire  [10:0] pc;
    wire  [11:0] ea;
    wire  [7:0]  opnd;
    wire  [3:0]  sp;
    wire  [1:0]  src;
    int          mismatches = 0, comparisons = 0;
    // Half period of 25 ns gives 20 MHz
    always #25 clk = ~clk;
    // Stack pointer load is left tied; the stack is exercised by entries and returns
    cia_core dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_EDGE_WAKEUP_REQUEST(req[2]),
        .I_PRIMARY_TIMER_REQUEST(req[1]), .I_SECONDARY_TIMER_REQUEST(req[0]), .I_EXEC(exec),
        .I_CLASS(cls), .I_MODE(mode), .I_LEN(len), .I_OPND1(op1), .I_OPND2(op2), .I_XPTR(xptr),
        .I_G_SET(g_set), .I_G_CLR(g_clr), .I_SP_LOAD(1'b0), .I_SP_VALUE(4'h0), .O_READY(ready),
        .O_PC(pc), .O_EA(ea), .O_OPERAND(opnd), .O_OPERAND_VALID(opv), .O_SP(sp), .O_G(g),
        .O_ENTRY(ent), .O_SOURCE(src));
    cia_periph u_periph (.i_clock(clk), .i_rst_b(rst_b), .i_raise(raise), .i_entry(ent),
        .i_source(src), .o_req(req));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded waits; each returns just after an edge so inputs never race it
    task automatic wait_on(input bit for_entry, output int n);
        for (n = 0; n < 400 && (for_entry ? ent : ready) !== 1'b1; n++) @(posedge clk) #1;
        if (n == 400) begin
            mismatches++;
            $display("Error at %0t: wait timed out got %h expected %h", $time, 1'b0, 1'b1);
            wrap_up();
        end
    endtask
    // Offer an instruction and hold it until the edge that takes it
    task automatic issue(input logic [2:0] c, m, input logic [1:0] l, input logic [7:0] a, b,
                         input logic [11:0] x);
        int n;
        // An edge passes first so exec never drops and rises in one step
        @(posedge clk) #1;
        {cls, mode, len, op1, op2, xptr, exec} = {c, m, l, a, b, x, 1'b1};
        wait_on(1'b0, n);
        @(posedge clk) #1;
        exec = 1'b0;
        if (c == CL_PLAIN) epc = epc + 11'(l);
    endtask
    task automatic t_reset();
        chk(12'(g), 12'h000);
        chk(12'(sp), 12'h00f);
        chk(12'(pc), 12'h000);
        $display("test reset done");
    endtask
    task automatic t_modes();
        issue(CL_PLAIN, MD_INDEXED, 2'h2, 8'hff, 8'h00, 12'h805);
        chk(ea, 12'h904);
        issue(CL_PLAIN, MD_INDEXED, 2'h2, 8'hff, 8'h00, 12'h7ff);
        chk(ea, 12'h0fe);
        issue(CL_PLAIN, MD_INDIRECT, 2'h1, 8'h00, 8'h00, 12'h8ab);
        chk(ea, 12'h0ab);
        issue(CL_PLAIN, MD_DIRECT, 2'h2, 8'h5a, 8'h00, 12'h8ff);
        chk(ea, 12'h05a);
        issue(CL_PLAIN, MD_IMMED, 2'h2, 8'hc3, 8'h00, 12'h000);
        chk({3'h0, opv, opnd}, 12'h1c3);
        issue(CL_PLAIN, MD_INHERENT, 2'h1, 8'h77, 8'h77, 12'h000);
        chk(12'(pc), 12'(epc));
        chk(ea, 12'h000);
        $display("test modes done");
    endtask
    task automatic t_jumps();
        issue(CL_SHORT_JUMP, MD_RELATIVE, 2'h1, 8'h00, 8'h00, 12'h000);
        epc = epc - 11'h01f;
        chk(12'(pc), 12'(epc));
        issue(CL_SHORT_JUMP, MD_RELATIVE, 2'h1, 8'h3f, 8'h00, 12'h000);
        epc = epc + 11'h020;
        chk(12'(pc), 12'(epc));
        issue(CL_LONG_JUMP, MD_ABSOLUTE, 2'h3, 8'h05, 8'h21, 12'h000);
        epc = 11'h521;
        chk(12'(pc), 12'(epc));
        issue(CL_LONG_JUMP, MD_DIRECT, 2'h2, 8'h05, 8'h21, 12'h000);
        epc = epc + 11'h002;
        chk(12'(pc), 12'(epc));
        issue(CL_LONG_JUMP, MD_INDEXED, 2'h2, 8'h10, 8'h00, 12'h8f0);
        epc = 11'h100;
        chk(12'(pc), 12'(epc));
        $display("test jumps done");
    endtask
    // Trap is taken whatever the enable; the return kind decides the enable after
    task automatic t_trap(input logic [2:0] rc, input logic gx);
        int n;
        issue(CL_TRAP, MD_INHERENT, 2'h1, 8'h00, 8'h00, 12'h000);
        wait_on(1'b1, n);
        chk(12'(n), 12'd100);
        chk({src, 1'b0, g, 4'h0, sp}, 12'h00d);
        chk(12'(pc), 12'(VEC_TRAP));
        issue(rc, MD_INHERENT, 2'h1, 8'h00, 8'h00, 12'h000);
        epc = epc + 11'h001;
        wait_on(1'b0, n);
        chk(12'(pc), 12'(epc));
        chk({3'h0, g, 4'h0, sp}, {3'h0, gx, 8'h0f});
        $display("test trap done");
    endtask
    task automatic t_irq();
        int n;
        raise = 3'h7;
        @(posedge clk) #1;
        raise = 3'h0;
        issue(CL_PLAIN, MD_INHERENT, 2'h1, 8'h00, 8'h00, 12'h000);
        chk(12'(pc), 12'(epc));
        g_set = 1'b1;
        @(posedge clk) #1;
        g_set = 1'b0;
        for (int s = 3; s > 0; s--) begin
            wait_on(1'b1, n);
            chk({src, 1'b0, g, pc[7:0]}, {2'(s), 2'h0, vt[s][7:0]});
            issue(CL_TRAP_RET, MD_INHERENT, 2'h1, 8'h00, 8'h00, 12'h000);
        end
        wait_on(1'b0, n);
        chk({g, pc}, {1'b1, epc});
        $display("test interrupts done");
    endtask
    // A call pushes the fall-through address; the plain return pulls it back
    task automatic t_call();
        int n;
        issue(CL_SUB_CALL, MD_ABSOLUTE, 2'h3, 8'h03, 8'h45, 12'h000);
        epc = epc + 11'h003;
        wait_on(1'b0, n);
        chk({g, pc}, 12'h345);
        chk(12'(sp), 12'h00d);
        issue(CL_SUB_RETURN, MD_INHERENT, 2'h1, 8'h00, 8'h00, 12'h000);
        wait_on(1'b0, n);
        chk({g, pc}, {1'b0, epc});
        chk(12'(sp), 12'h00f);
        $display("test call done");
    endtask
    // Reset falls just after time zero so every register sees an edge of it
    initial begin
        #1 rst_b = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        t_reset();
        t_modes();
        t_jumps();
        t_call();
        t_trap(CL_SUB_RETURN, 1'b0);
        t_irq();
        t_trap(CL_TRAP_RET, 1'b1);
        g_clr = 1'b1;
        @(posedge clk) #1;
        g_clr = 1'b0;
        chk(12'(g), 12'h000);
        g_set = 1'b1;
        @(posedge clk) #1;
        g_set = 1'b0;
        chk(12'(g), 12'h001);
        // Second reset in mid-run must clear a set enable again
        rst_b = 1'b0;
        @(posedge clk) #1;
        rst_b = 1'b1;
        t_reset();
        wrap_up();
    end
endmodule // cia_core_tb_top
`default_nettype wire
